/* design/gpib_bus_if.sv */
// shared bus wiring: each party pulls lines low through its enables
// assumes open-drain lines with pull-ups; the resolved level is high unless pulled
`timescale 1ns/1ns
`default_nettype none
interface gpib_bus_if;
	logic [7:0] dev_dio_oe, ctl_dio_oe;
	logic       dev_dav_oe, dev_nrfd_oe, dev_ndac_oe, dev_eoi_oe, dev_srq_oe;
	logic       ctl_dav_oe, ctl_nrfd_oe, ctl_ndac_oe, ctl_eoi_oe;
	logic       ctl_atn_oe, ctl_ifc_oe, ctl_ren_oe;
	logic [7:0] dio_n;
	logic       dav_n, nrfd_n, ndac_n, eoi_n, atn_n, ifc_n, ren_n, srq_n;

	// wired-or of true levels, one pull low is enough
	assign dio_n  = ~(dev_dio_oe | ctl_dio_oe);
	assign dav_n  = ~(dev_dav_oe | ctl_dav_oe);
	assign nrfd_n = ~(dev_nrfd_oe | ctl_nrfd_oe);
	assign ndac_n = ~(dev_ndac_oe | ctl_ndac_oe);
	assign eoi_n  = ~(dev_eoi_oe | ctl_eoi_oe);
	assign atn_n  = ~ctl_atn_oe;
	assign ifc_n  = ~ctl_ifc_oe;
	assign ren_n  = ~ctl_ren_oe;
	assign srq_n  = ~dev_srq_oe;

	modport dev (
		output dev_dio_oe, dev_dav_oe, dev_nrfd_oe, dev_ndac_oe, dev_eoi_oe, dev_srq_oe,
		input  dio_n, dav_n, nrfd_n, ndac_n, eoi_n, atn_n, ifc_n, ren_n
	);
	modport ctl (
		output ctl_dio_oe, ctl_dav_oe, ctl_nrfd_oe, ctl_ndac_oe, ctl_eoi_oe, ctl_atn_oe, ctl_ifc_oe, ctl_ren_oe,
		input  dio_n, dav_n, nrfd_n, ndac_n, eoi_n, srq_n
	);
endinterface
`default_nettype wire

/* design/gpib_ctl.sv */
// controller end of the bus: sources commands and data, may listen
// assumes the bus arrives through gpib_bus_if and the user issues bytes on sys_clk
`timescale 1ns/1ns
`default_nettype none
module gpib_ctl (
	input  wire logic       sys_clk,   // 250 MHz clock
	input  wire logic       reset,     // sync reset, high
	gpib_bus_if.ctl         bus,       // bus lines
	input  wire logic       ifc_req,   // hold interface clear
	input  wire logic       ren_req,   // hold remote enable
	input  wire logic       cmd_valid, // byte offered
	input  wire logic [7:0] cmd_data,  // byte
	input  wire logic       cmd_atn,   // byte is a bus command
	input  wire logic       cmd_eoi,   // final data byte
	output logic            cmd_ready, // byte taken
	input  wire logic       lsn_en,    // act as listener, ATN released
	output logic            rx_valid,  // one-cycle byte pulse
	output logic      [7:0] rx_data,   // received byte
	output logic            rx_eoi,    // received byte marked last
	output logic            srq        // service request seen
);
	import gpib_pkg::*;

	logic [11:0]         sync1_r, sync2_r;
	logic                dav, nrfd_n, ndac_n, eoi;
	logic                srq_meta_r;
	logic [SETTLE_W-1:0] settle_r;
	gpib_src_t           src_r;
	gpib_acc_t           acc_r;

	// ***********************************
	// pin synchroniser and uniline drive
	// ***********************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync1_r <= '1;
			sync2_r <= '1;
		end else begin
			sync1_r <= {bus.dio_n, bus.dav_n, bus.nrfd_n, bus.ndac_n, bus.eoi_n};
			sync2_r <= sync1_r;
		end
	end

	assign dav    = !sync2_r[3];
	assign nrfd_n = sync2_r[2];
	assign ndac_n = sync2_r[1];
	assign eoi    = !sync2_r[0];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bus.ctl_ifc_oe <= 1'b0;
			bus.ctl_ren_oe <= 1'b0;
			srq_meta_r     <= 1'b1;
			srq            <= 1'b0;
		end else begin
			bus.ctl_ifc_oe <= ifc_req;
			bus.ctl_ren_oe <= ren_req;
			// the service line is a pin like the others, so two flops before use
			srq_meta_r     <= bus.srq_n;
			srq            <= !srq_meta_r;
		end
	end

	// ***********************************
	// source handshake
	// ***********************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			src_r          <= S_IDLE;
			bus.ctl_dio_oe <= DIO_IDLE;
			bus.ctl_dav_oe <= 1'b0;
			bus.ctl_eoi_oe <= 1'b0;
			bus.ctl_atn_oe <= 1'b0;
			settle_r       <= SETTLE_RST;
			cmd_ready      <= 1'b0;
		end else begin
			cmd_ready <= 1'b0;
			case (src_r)
				S_IDLE: begin
					bus.ctl_dav_oe <= 1'b0;
					bus.ctl_dio_oe <= DIO_IDLE;
					bus.ctl_eoi_oe <= 1'b0;
					if (cmd_valid && cmd_ready) begin
						bus.ctl_dio_oe <= cmd_data;
						bus.ctl_eoi_oe <= cmd_eoi && !cmd_atn;
						bus.ctl_atn_oe <= cmd_atn;
						// fresh ATN needs the listeners' lines to settle first
						settle_r       <= (cmd_atn && !bus.ctl_atn_oe) ? SETTLE_W'(ATN_SETTLE_CYC) : SETTLE_RST;
						src_r          <= S_SETTLE;
					end else begin
						if (lsn_en) begin
							bus.ctl_atn_oe <= 1'b0;
						end
						cmd_ready <= !lsn_en;
					end
				end
				S_SETTLE: begin
					settle_r <= settle_r - SETTLE_W'(settle_r != SETTLE_RST);
					if (settle_r == SETTLE_RST) begin
						src_r <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (nrfd_n && !ndac_n) begin
						bus.ctl_dav_oe <= 1'b1;
						src_r          <= S_ACK;
					end
				end
				S_ACK: begin
					if (ndac_n) begin
						bus.ctl_dav_oe <= 1'b0;
						src_r          <= S_IDLE;
					end
				end
				default: src_r <= S_IDLE;
			endcase
		end
	end

	// ***********************************
	// listener handshake, never stalls
	// ***********************************
	always_ff @(posedge sys_clk) begin
		rx_valid <= 1'b0;
		if (reset) begin
			acc_r           <= A_IDLE;
			bus.ctl_nrfd_oe <= 1'b0;
			bus.ctl_ndac_oe <= 1'b0;
			rx_data         <= DIO_IDLE;
			rx_eoi          <= 1'b0;
		end else begin
			case (acc_r)
				A_IDLE: begin
					bus.ctl_nrfd_oe <= 1'b0;
					bus.ctl_ndac_oe <= lsn_en && !bus.ctl_atn_oe;
					if (lsn_en && !bus.ctl_atn_oe && dav) begin
						rx_data         <= bus_byte(sync2_r[11:4]);
						rx_eoi          <= eoi;
						rx_valid        <= 1'b1;
						bus.ctl_nrfd_oe <= 1'b1;
						bus.ctl_ndac_oe <= 1'b0;
						acc_r           <= A_WAIT;
					end
				end
				A_WAIT: begin
					if (!dav) begin
						acc_r <= A_IDLE;
					end
				end
				default: acc_r <= A_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* design/gpib_dev.sv */
// instrument end of the bus: acceptor, talker, address and command decode
// assumes the bus arrives through gpib_bus_if and user logic runs on sys_clk
`timescale 1ns/1ns
`default_nettype none

// ***********************************
// receive buffer
// ***********************************
module gpib_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input  wire logic             sys_clk,   // clock
	input  wire logic             reset,     // sync reset
	input  wire logic             in_valid,  // write request
	input  wire logic [WIDTH-1:0] in_data,   // write word
	output logic                  in_ready,  // room left
	output logic                  out_valid, // word held
	output logic      [WIDTH-1:0] out_data,  // held word
	input  wire logic             out_ready  // consumer takes
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r, rd_r;
	logic [AW:0]      cnt_r;
	logic             push, pop;

	assign in_ready = cnt_r != (AW+1)'(DEPTH);
	assign push     = in_valid && in_ready;
	// refill the output register whenever it empties or is taken
	assign pop      = (cnt_r != '0) && (!out_valid || out_ready);

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			wr_r  <= wr_r + AW'(push);
			rd_r  <= rd_r + AW'(pop);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data  <= mem_r[rd_r];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule

// ***********************************
// instrument end
// ***********************************
module gpib_dev (
	input  wire logic       sys_clk,     // 250 MHz clock
	input  wire logic       reset,       // sync reset, high
	gpib_bus_if.dev         bus,         // bus lines
	input  wire logic [4:0] pad,         // primary address 0..30
	input  wire logic       tx_valid,    // talk byte offered
	input  wire logic [7:0] tx_data,     // talk byte
	input  wire logic       tx_last,     // final byte of message
	output logic            tx_ready,    // talk byte taken
	output logic            rx_valid,    // data byte held
	output logic      [7:0] rx_data,     // data byte
	output logic            rx_eoi,      // byte was marked last
	input  wire logic       rx_ready,    // consumer takes byte
	input  wire logic       rsv,         // service wanted
	input  wire logic [7:0] status_byte, // poll answer, bit 6 replaced
	output logic            listen,      // listen addressed
	output logic            talk,        // talk addressed
	output logic            remote,      // remote operation
	output logic            lockout,     // front panel locked
	output logic            spoll,       // serial poll mode
	output logic            trigger,     // one-cycle trigger pulse
	output logic            dev_clear    // one-cycle clear pulse
);
	import gpib_pkg::*;

	logic [14:0] sync1_r, sync2_r;
	logic [7:0]  bus_dio_n;
	logic        dav, nrfd_n, ndac_n, eoi, atn, ifc, ren;
	logic        take, fifo_rdy, rx_stb_r, cmd_stb_r, rx_eoi_r, polled_r;
	logic [7:0]  rx_byte_r;
	logic [6:0]  cmd;
	logic        src_en;
	gpib_acc_t   acc_r;
	gpib_src_t   src_r;

	// ***********************************
	// pin synchroniser
	// ***********************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync1_r <= '1;
			sync2_r <= '1;
		end else begin
			sync1_r <= {bus.dio_n, bus.dav_n, bus.nrfd_n, bus.ndac_n, bus.eoi_n, bus.atn_n, bus.ifc_n, bus.ren_n};
			sync2_r <= sync1_r;
		end
	end

	assign bus_dio_n = sync2_r[14:7];
	assign dav       = !sync2_r[6];
	assign nrfd_n    = sync2_r[5];
	assign ndac_n    = sync2_r[4];
	assign eoi       = !sync2_r[3];
	assign atn       = !sync2_r[2];
	assign ifc       = !sync2_r[1];
	assign ren       = !sync2_r[0];
	assign cmd       = rx_byte_r[6:0];
	// commands are always heard; data only while listen addressed
	assign take      = atn || listen;
	assign src_en    = talk && !atn;

	// ***********************************
	// acceptor handshake
	// ***********************************
	always_ff @(posedge sys_clk) begin
		rx_stb_r  <= 1'b0;
		cmd_stb_r <= 1'b0;
		if (reset || ifc) begin
			acc_r           <= A_IDLE;
			bus.dev_nrfd_oe <= 1'b0;
			bus.dev_ndac_oe <= 1'b0;
			rx_byte_r       <= DIO_IDLE;
			rx_eoi_r        <= 1'b0;
		end else begin
			case (acc_r)
				A_IDLE: begin
					bus.dev_ndac_oe <= take;
					// a full buffer holds the source off instead of losing bytes
					bus.dev_nrfd_oe <= take && !(atn || fifo_rdy);
					if (take && dav && (atn || fifo_rdy)) begin
						rx_byte_r       <= bus_byte(bus_dio_n);
						rx_eoi_r        <= eoi;
						cmd_stb_r       <= atn;
						rx_stb_r        <= !atn;
						bus.dev_nrfd_oe <= 1'b1;
						bus.dev_ndac_oe <= 1'b0;
						acc_r           <= A_WAIT;
					end
				end
				A_WAIT: begin
					if (!dav) begin
						bus.dev_ndac_oe <= take;
						acc_r           <= A_IDLE;
					end
				end
				default: acc_r <= A_IDLE;
			endcase
		end
	end

	gpib_fifo #(
		.WIDTH(RX_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.in_valid (rx_stb_r),
		.in_data  ({rx_eoi_r, rx_byte_r}),
		.in_ready (fifo_rdy),
		.out_valid(rx_valid),
		.out_data ({rx_eoi, rx_data}),
		.out_ready(rx_ready)
	);

	// ***********************************
	// address state and command decode
	// ***********************************
	always_ff @(posedge sys_clk) begin
		if (reset || ifc) begin
			listen <= 1'b0;
			talk   <= 1'b0;
			spoll  <= 1'b0;
		end else if (cmd_stb_r) begin
			if (addr_hit(cmd, LAG_BASE, pad)) begin
				listen <= 1'b1;
			end else if (cmd == CMD_UNL) begin
				listen <= 1'b0;
			end
			if (addr_hit(cmd, TAG_BASE, pad)) begin
				talk <= 1'b1;
			end else if (cmd[6:5] == GRP_TAG) begin
				// another talk address or untalk: only one talker on the bus
				talk <= 1'b0;
			end
			if (cmd == CMD_SPE) begin
				spoll <= 1'b1;
			end else if (cmd == CMD_SPD) begin
				spoll <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			remote  <= 1'b0;
			lockout <= 1'b0;
		end else if (!ren) begin
			remote  <= 1'b0;
			lockout <= 1'b0;
		end else if (cmd_stb_r) begin
			if (addr_hit(cmd, LAG_BASE, pad)) begin
				remote <= 1'b1;
			end
			if (cmd == CMD_LLO) begin
				lockout <= 1'b1;
			end
			if (listen && cmd == CMD_GTL) begin
				remote  <= 1'b0;
				lockout <= 1'b0;
			end
		end
	end

	// pulses do not depend on REN: clear and trigger act in local mode as well
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			trigger   <= 1'b0;
			dev_clear <= 1'b0;
		end else begin
			dev_clear <= cmd_stb_r && ((cmd == CMD_DCL) || (listen && cmd == CMD_SDC));
			trigger   <= cmd_stb_r && listen && cmd == CMD_GET;
		end
	end

	// ***********************************
	// service request
	// ***********************************
	always_ff @(posedge sys_clk) begin
		if (reset || !rsv) begin
			polled_r       <= 1'b0;
			bus.dev_srq_oe <= 1'b0;
		end else begin
			// held until the controller has read our status in a poll
			if (src_r == S_ACK && ndac_n && spoll) begin
				polled_r <= 1'b1;
			end
			bus.dev_srq_oe <= !polled_r;
		end
	end

	// ***********************************
	// source handshake
	// ***********************************
	always_ff @(posedge sys_clk) begin
		if (reset || ifc) begin
			src_r          <= S_IDLE;
			bus.dev_dio_oe <= DIO_IDLE;
			bus.dev_dav_oe <= 1'b0;
			bus.dev_eoi_oe <= 1'b0;
			tx_ready       <= 1'b0;
		end else begin
			tx_ready <= 1'b0;
			case (src_r)
				S_IDLE: begin
					bus.dev_dav_oe <= 1'b0;
					if (src_en && spoll) begin
						bus.dev_dio_oe <= {status_byte[7], bus.dev_srq_oe, status_byte[5:0]};
						bus.dev_eoi_oe <= 1'b0;
						src_r          <= S_WAIT;
					end else if (src_en && tx_valid && tx_ready) begin
						bus.dev_dio_oe <= tx_data;
						bus.dev_eoi_oe <= tx_last;
						src_r          <= S_WAIT;
					end else begin
						tx_ready <= src_en && !spoll;
					end
				end
				S_WAIT: begin
					if (!src_en) begin
						src_r <= S_SETTLE;
					end else if (nrfd_n && !ndac_n) begin
						bus.dev_dav_oe <= 1'b1;
						src_r          <= S_ACK;
					end
				end
				S_ACK: begin
					if (!src_en || ndac_n) begin
						src_r <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					// ATN or acceptance both end our drive of the lines
					bus.dev_dav_oe <= 1'b0;
					bus.dev_dio_oe <= DIO_IDLE;
					bus.dev_eoi_oe <= 1'b0;
					src_r          <= S_IDLE;
				end
				default: src_r <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* design/gpib_pkg.sv */
// constants, types and decode helpers shared by both ends of the bus link
// assumes one 250 MHz clock on each end and active low open-drain bus lines
`default_nettype none
package gpib_pkg;
	// ***********************************
	// timing
	// ***********************************
	localparam int CLK_PERIOD_NS  = 4;
	localparam int ATN_SETTLE_NS  = 100;
	localparam int ATN_SETTLE_CYC = (ATN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W       = 6;

	// ***********************************
	// multiline command codes, seven bits, plus the two-bit talk group and five-bit address limit
	// ***********************************
	localparam logic [6:0] CMD_GTL  = 7'h01;
	localparam logic [6:0] CMD_SDC  = 7'h04;
	localparam logic [6:0] CMD_GET  = 7'h08;
	localparam logic [6:0] CMD_LLO  = 7'h11;
	localparam logic [6:0] CMD_DCL  = 7'h14;
	localparam logic [6:0] CMD_SPE  = 7'h18;
	localparam logic [6:0] CMD_SPD  = 7'h19;
	localparam logic [6:0] CMD_UNL  = 7'h3F;
	localparam logic [6:0] CMD_UNT  = 7'h5F;
	localparam logic [6:0] LAG_BASE = 7'h20;
	localparam logic [6:0] TAG_BASE = 7'h40;
	localparam logic [1:0] GRP_TAG  = 2'h2;
	localparam logic [4:0] PAD_MAX  = 5'h1E;

	// ***********************************
	// storage and reset values
	// ***********************************
	localparam int         FIFO_DEPTH = 32;
	localparam int         RX_W       = 9;
	localparam logic [7:0] DIO_IDLE   = 8'h00;
	localparam logic [5:0] SETTLE_RST = 6'h00;

	typedef enum logic [1:0] {A_IDLE, A_WAIT} gpib_acc_t;
	typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_WAIT, S_ACK} gpib_src_t;

	// own address match: primary address ORed into the group base
	function automatic logic addr_hit(input logic [6:0] c, input logic [6:0] base, input logic [4:0] pad);
		addr_hit = (pad <= PAD_MAX) && (c == (base | {2'h0, pad}));
	endfunction

	// true-level byte from the low-true data lines
	function automatic logic [7:0] bus_byte(input logic [7:0] dio_n);
		bus_byte = ~dio_n;
	endfunction
endpackage
`default_nettype wire

/* tb/gpib_assertions.sv */
// checker for the handshake and control lines between the two bus ends
// assumes plain copies of the interface signals, one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module gpib_assertions (
	input wire logic       sys_clk,     // clock
	input wire logic       reset,       // sync reset
	input wire logic [7:0] ctl_dio_oe,  // controller data pulls
	input wire logic [7:0] dev_dio_oe,  // instrument data pulls
	input wire logic       ctl_dav_oe,  // controller valid
	input wire logic       dev_dav_oe,  // instrument valid
	input wire logic       dev_nrfd_oe, // instrument not ready
	input wire logic       dev_ndac_oe, // instrument not accepted
	input wire logic       dev_eoi_oe,  // instrument end mark
	input wire logic       ctl_eoi_oe,  // controller end mark
	input wire logic       ctl_atn_oe,  // attention
	input wire logic       ctl_ifc_oe,  // interface clear
	input wire logic       nrfd_n,      // resolved not ready
	input wire logic       ndac_n       // resolved not accepted
);
	import gpib_pkg::*;
	// ***********************************
	// attention age
	// ***********************************
	logic [5:0] atn_cnt_r;
	always_ff @(posedge sys_clk) begin
		if (reset || !ctl_atn_oe)
			atn_cnt_r <= 6'h00;
		else if (atn_cnt_r != 6'h3F)
			atn_cnt_r <= atn_cnt_r + 6'h01;
	end
	// ***********************************
	// properties
	// ***********************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_ctl_cmd;
		$rose(ctl_dav_oe) ##0 ctl_atn_oe;
	endsequence
	sequence s_acc_took;
		##[1:8] (dev_nrfd_oe && !dev_ndac_oe);
	endsequence
	property p_acc_answer;
		s_ctl_cmd |-> s_acc_took;
	endproperty
	a_acc_answer: assert property (p_acc_answer) else $error("command byte not accepted");
	property p_dav_ready;
		$rose(ctl_dav_oe) || $rose(dev_dav_oe) |-> $past(nrfd_n) && !$past(ndac_n);
	endproperty
	a_dav_ready: assert property (p_dav_ready) else $error("valid raised before ready");
	property p_atn_settle;
		s_ctl_cmd |-> atn_cnt_r >= ATN_SETTLE_CYC;
	endproperty
	a_atn_settle: assert property (p_atn_settle) else $error("valid too soon after attention");
	property p_ctl_release;
		$fell(ctl_dav_oe) |-> $past(ndac_n);
	endproperty
	a_ctl_release: assert property (p_ctl_release) else $error("controller valid dropped early");
	property p_dev_release;
		$fell(dev_dav_oe) && !ctl_atn_oe && !ctl_ifc_oe |-> $past(ndac_n);
	endproperty
	a_dev_release: assert property (p_dev_release) else $error("instrument valid dropped early");
	property p_acc_order;
		$fell(dev_ndac_oe) && ctl_dav_oe |-> dev_nrfd_oe;
	endproperty
	a_acc_order: assert property (p_acc_order) else $error("accepted without not ready");
	property p_ctl_stable;
		ctl_dav_oe && $past(ctl_dav_oe) |-> $stable(ctl_dio_oe) && $stable(ctl_atn_oe);
	endproperty
	a_ctl_stable: assert property (p_ctl_stable) else $error("controller byte moved while valid");
	property p_dev_stable;
		dev_dav_oe && $past(dev_dav_oe) |-> $stable(dev_dio_oe) && $stable(dev_eoi_oe);
	endproperty
	a_dev_stable: assert property (p_dev_stable) else $error("instrument byte moved while valid");
	property p_atn_owner;
		ctl_atn_oe [*5] |-> !dev_dav_oe;
	endproperty
	a_atn_owner: assert property (p_atn_owner) else $error("instrument sources under attention");
	property p_eoi_data;
		ctl_eoi_oe |-> !ctl_atn_oe;
	endproperty
	a_eoi_data: assert property (p_eoi_data) else $error("end mark on a command byte");
	property p_ifc_idle;
		ctl_ifc_oe [*5] |-> !dev_dav_oe && dev_dio_oe == 8'h00;
	endproperty
	a_ifc_idle: assert property (p_ifc_idle) else $error("talker busy under clear");
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench: controller and instrument joined on one bus
// assumes the package and design files are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import gpib_pkg::*;
	localparam logic [6:0] MY_LAG = LAG_BASE | 7'h1E;
	localparam logic [6:0] MY_TAG = TAG_BASE | 7'h1E;
	logic       sys_clk, reset, ifc_req, ren_req, cmd_valid, cmd_atn, cmd_eoi, cmd_ready, lsn_en, srq;
	logic       c_rx_valid, c_rx_eoi, tx_valid, tx_last, tx_ready, rx_valid, rx_eoi, rx_ready, rsv;
	logic       listen, talk, remote, lockout, spoll, trigger, dev_clear;
	logic [7:0] cmd_data, c_rx_data, tx_data, rx_data, status_byte;
	logic [8:0] rxq[$];
	int         n_fail, num_checks, n_trig, n_clr;
	gpib_bus_if bus();
	gpib_ctl gpib_ctl_i (.sys_clk(sys_clk), .reset(reset), .bus(bus), .ifc_req(ifc_req), .ren_req(ren_req),
		.cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_atn(cmd_atn), .cmd_eoi(cmd_eoi), .cmd_ready(cmd_ready),
		.lsn_en(lsn_en), .rx_valid(c_rx_valid), .rx_data(c_rx_data), .rx_eoi(c_rx_eoi), .srq(srq));
	gpib_dev gpib_dev_i (.sys_clk(sys_clk), .reset(reset), .bus(bus), .pad(5'h1E), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_eoi(rx_eoi), .rx_ready(rx_ready), .rsv(rsv), .status_byte(status_byte), .listen(listen),
		.talk(talk), .remote(remote), .lockout(lockout), .spoll(spoll), .trigger(trigger), .dev_clear(dev_clear));
	gpib_assertions gpib_assertions_i (.sys_clk(sys_clk), .reset(reset), .ctl_dio_oe(bus.ctl_dio_oe),
		.dev_dio_oe(bus.dev_dio_oe), .ctl_dav_oe(bus.ctl_dav_oe), .dev_dav_oe(bus.dev_dav_oe),
		.dev_nrfd_oe(bus.dev_nrfd_oe), .dev_ndac_oe(bus.dev_ndac_oe), .dev_eoi_oe(bus.dev_eoi_oe),
		.ctl_eoi_oe(bus.ctl_eoi_oe), .ctl_atn_oe(bus.ctl_atn_oe), .ctl_ifc_oe(bus.ctl_ifc_oe),
		.nrfd_n(bus.nrfd_n), .ndac_n(bus.ndac_n));
	// ***********************************
	// clock and monitors
	// ***********************************
	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	// pulses are read mid-cycle so they never race the launching edge
	always @(negedge sys_clk) begin
		if (trigger === 1'h1)
			n_trig++;
		if (dev_clear === 1'h1)
			n_clr++;
		if (c_rx_valid === 1'h1)
			rxq.push_back({c_rx_eoi, c_rx_data});
	end
	// ***********************************
	// shared tasks
	// ***********************************
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic give_up;
		n_fail++;
		$display("FAIL wait expected 1 seen 0");
		wrap_up();
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic chk1(input string nm, input logic seen, input logic exp);
		chk(nm, {7'h00, seen}, {7'h00, exp});
	endtask
	task automatic idle;
		for (int i = 0; cmd_ready !== 1'h1; i++) begin
			if (i > 3000)
				give_up();
			@(negedge sys_clk);
		end
	endtask
	task automatic send(input logic [7:0] d, input logic a, input logic e);
		cmd_data = d;
		cmd_atn = a;
		cmd_eoi = e;
		cmd_valid = 1'h1;
		idle();
		@(negedge sys_clk);
		cmd_valid = 1'h0;
		// an edge passes before the next request may raise valid again
		@(negedge sys_clk);
	endtask
	task automatic cmd(input logic [6:0] c);
		send({1'h0, c}, 1'h1, 1'h0);
		idle();
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic talk_byte(input logic [7:0] d, input logic l);
		tx_data = d;
		tx_last = l;
		tx_valid = 1'h1;
		for (int i = 0; tx_ready !== 1'h1; i++) begin
			if (i > 3000)
				give_up();
			@(negedge sys_clk);
		end
		@(negedge sys_clk);
		tx_valid = 1'h0;
		@(negedge sys_clk);
	endtask
	task automatic wait_q(input int n);
		for (int i = 0; rxq.size() < n; i++) begin
			if (i > 3000)
				give_up();
			@(negedge sys_clk);
		end
	endtask
	// ***********************************
	// scenarios
	// ***********************************
	task automatic t_addr;
		ren_req = 1'h1;
		cmd(CMD_GET);
		chk("trig", 8'(n_trig), 8'h00);
		cmd(MY_LAG);
		chk1("listen", listen, 1'h1);
		chk1("remote", remote, 1'h1);
		cmd(MY_TAG);
		chk1("talk", talk, 1'h1);
		cmd(7'h41);
		chk1("talk", talk, 1'h0);
		cmd(MY_TAG);
		cmd(CMD_UNT);
		chk1("talk", talk, 1'h0);
		cmd(CMD_UNL);
		chk1("listen", listen, 1'h0);
		cmd(7'h3D);
		chk1("listen", listen, 1'h0);
	endtask
	task automatic t_univ;
		cmd(CMD_DCL);
		chk("clear", 8'(n_clr), 8'h01);
		cmd(CMD_SDC);
		chk("clear", 8'(n_clr), 8'h01);
		cmd(CMD_LLO);
		chk1("lockout", lockout, 1'h1);
		cmd(MY_LAG);
		cmd(CMD_SDC);
		chk("clear", 8'(n_clr), 8'h02);
		cmd(CMD_GET);
		chk("trig", 8'(n_trig), 8'h01);
		cmd(CMD_GTL);
		chk1("remote", remote, 1'h0);
		chk1("lockout", lockout, 1'h0);
	endtask
	// fills the receive buffer until the bus stalls, then drains it
	task automatic t_data;
		for (int i = 0; i < 34; i++)
			send(8'h30 + 8'(i), 1'h0, i == 33);
		repeat (100) @(negedge sys_clk);
		chk1("ready", cmd_ready, 1'h0);
		chk1("listen", listen, 1'h1);
		rx_ready = 1'h1;
		for (int i = 0; i < 34; i++) begin
			for (int j = 0; rx_valid !== 1'h1; j++) begin
				if (j > 300)
					give_up();
				@(negedge sys_clk);
			end
			chk("rx_data", rx_data, 8'h30 + 8'(i));
			chk1("rx_eoi", rx_eoi, i == 33);
			@(negedge sys_clk);
		end
		idle();
		chk1("rx_valid", rx_valid, 1'h0);
	endtask
	task automatic t_talk;
		cmd(CMD_UNL);
		cmd(MY_TAG);
		lsn_en = 1'h1;
		talk_byte(8'hA5, 1'h0);
		talk_byte(8'h5A, 1'h1);
		wait_q(2);
		chk("byte0", rxq[0][7:0], 8'hA5);
		chk("byte1", rxq[1][7:0], 8'h5A);
		chk1("eoi0", rxq[0][8], 1'h0);
		chk1("eoi1", rxq[1][8], 1'h1);
		rsv = 1'h1;
		repeat (10) @(negedge sys_clk);
		chk1("srq", srq, 1'h1);
		lsn_en = 1'h0;
		cmd(CMD_SPE);
		chk1("spoll", spoll, 1'h1);
		rxq.delete();
		lsn_en = 1'h1;
		wait_q(1);
		chk("status", rxq[0][7:0], status_byte | 8'h40);
		repeat (20) @(negedge sys_clk);
		chk1("srq", srq, 1'h0);
		lsn_en = 1'h0;
		cmd(CMD_SPD);
		chk1("spoll", spoll, 1'h0);
		rsv = 1'h0;
	endtask
	task automatic t_ifc;
		cmd(MY_LAG);
		cmd(CMD_SPE);
		ifc_req = 1'h1;
		repeat (10) @(negedge sys_clk);
		ifc_req = 1'h0;
		repeat (4) @(negedge sys_clk);
		chk1("listen", listen, 1'h0);
		chk1("talk", talk, 1'h0);
		chk1("spoll", spoll, 1'h0);
		chk1("remote", remote, 1'h1);
		ren_req = 1'h0;
		repeat (6) @(negedge sys_clk);
		chk1("remote", remote, 1'h0);
		cmd(CMD_DCL);
		chk("clear", 8'(n_clr), 8'h03);
	endtask
	// ***********************************
	// main sequence
	// ***********************************
	initial begin
		reset = 1'h1;
		ifc_req = 1'h0;
		ren_req = 1'h0;
		cmd_valid = 1'h0;
		cmd_data = 8'h00;
		cmd_atn = 1'h0;
		cmd_eoi = 1'h0;
		lsn_en = 1'h0;
		tx_valid = 1'h0;
		tx_data = 8'h00;
		tx_last = 1'h0;
		rx_ready = 1'h0;
		rsv = 1'h0;
		status_byte = 8'h05;
		repeat (10) @(negedge sys_clk);
		reset = 1'h0;
		t_addr();
		t_univ();
		t_data();
		t_talk();
		t_ifc();
		wrap_up();
	end
endmodule
`default_nettype wire
